// File: verif/host_master.sv
// Backplane host master model, one cycle at a time
`timescale 1ns/1ps
module host_master (
  input wire i_clock,
  input wire i_dtack_n,
  input wire [15:0] i_data,
  output logic [23:1] o_addr,
  output logic [5:0] o_am,
  output logic o_as_n,
  output logic o_ds0_n,
  output logic o_ds1_n,
  output logic o_write_n,
  output logic [15:0] o_data,
  output logic o_iack_n,
  output logic [2:0] o_iack_level
);
  initial {o_as_n, o_ds0_n, o_ds1_n, o_write_n, o_iack_n} = 5'h1F;
  initial {o_addr, o_am, o_data, o_iack_level} = '0;
  // Released address and data lines show the inverse so stale values are never mistaken
  task xfer(input logic wr, input logic iack, input logic [23:1] a, input logic [5:0] am,
    input logic [1:0] be, input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge i_clock);
    #1;
    o_addr = a;
    o_am = am;
    o_write_n = !wr;
    o_data = wd;
    o_iack_n = !iack;
    o_iack_level = a[3:1];
    o_as_n = 1'b0;
    o_ds0_n = !be[0];
    o_ds1_n = !be[1];
    for (n = 0; n < 30 && !ok; n++) begin
      @(posedge i_clock);
      ok = !i_dtack_n;
    end
    rd = i_data;
    #1;
    {o_as_n, o_ds0_n, o_ds1_n, o_iack_n} = 4'hF;
    o_data = ~wd;
    o_addr = ~a;
    for (n = 0; n < 30 && !i_dtack_n; n++) @(posedge i_clock);
    #1;
  endtask
endmodule

// File: verif/slave_port_assertions.sv
// Pin-level checks on the backplane slave port
`timescale 1ns/1ps
module slave_port_assertions #(
  parameter WDOG_CYCLES = 50
) (
  input wire i_clock,
  input wire i_rst,
  input wire [23:1] i_vme_addr,
  input wire [5:0] i_vme_am,
  input wire i_vme_as_n,
  input wire i_vme_write_n,
  input wire i_vme_iack_n,
  input wire [2:0] i_jmp_base,
  input wire [5:0] i_jmp_am,
  input wire i_loc_error,
  input wire i_wdog_kick,
  input wire o_vme_data_oe,
  input wire o_vme_dtack_n,
  input wire [6:0] o_vme_irq_n,
  input wire o_sysfail_n,
  input wire o_loc_irq,
  input wire o_loc_reset
);
  reg [7:0] hold_reg;
  reg [15:0] idle_reg;
  reg kick_reg;
  // Counters saturate so a long run cannot wrap them
  always @(posedge i_clock) begin
    kick_reg <= i_wdog_kick;
    if (i_rst || !o_loc_reset) hold_reg <= 8'h00;
    else if (hold_reg != 8'hFF) hold_reg <= hold_reg + 8'h01;
    if (i_rst || kick_reg != i_wdog_kick) idle_reg <= 16'h0000;
    else if (idle_reg != 16'hFFFF) idle_reg <= idle_reg + 16'h0001;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  reset_state_a: assert property (disable iff (1'b0) i_rst |=> o_vme_dtack_n
    && !o_vme_data_oe && o_vme_irq_n == 7'h7F && !o_sysfail_n && o_loc_reset) else $error("reset");
  reset_length_a: assert property ($fell(o_loc_reset) |-> hold_reg >= 8'h0F
    && hold_reg <= 8'h11) else $error("local reset length");
  irq_pulse_a: assert property (o_loc_irq |=> !o_loc_irq) else $error("irq pulse");
  ack_release_a: assert property (!o_vme_dtack_n && i_vme_as_n |-> ##[1:4] o_vme_dtack_n)
    else $error("dtack held");
  ack_match_a: assert property ($fell(o_vme_dtack_n) && i_vme_iack_n |-> i_vme_am == i_jmp_am
    && i_vme_addr[23:17] == {4'h0, i_jmp_base} && !i_vme_as_n) else $error("bad decode");
  read_drive_a: assert property (!o_vme_dtack_n |-> o_vme_data_oe == i_vme_write_n)
    else $error("data drive");
  error_fail_a: assert property (i_loc_error [*5] |-> !o_sysfail_n) else $error("error fail");
  wdog_fail_a: assert property (idle_reg > WDOG_CYCLES + 8 |-> !o_sysfail_n)
    else $error("watchdog fail");
  cover property ($rose(o_loc_irq));
  cover property ($fell(o_loc_reset));
  cover property ($fell(o_vme_dtack_n) && !i_vme_iack_n);
endmodule

// File: verif/test_vme_slave_dpr_port.sv
// Self-checking bench for the backplane slave port
`timescale 1ns/1ps
module test_vme_slave_dpr_port;
  localparam int WDOG = 50;
  logic i_clock = 1'b0, i_rst = 1'b1, i_loc_cycle = 1'b0, i_loc_we = 1'b0, ok;
  logic i_loc_init_done = 1'b0, i_loc_error = 1'b0, i_wdog_kick = 1'b0, kick_en = 1'b1, rnd = 1'b0;
  logic [1:0] i_loc_be = 2'h3;
  logic [15:1] i_loc_addr = 15'h0000;
  logic [15:0] i_loc_wdata = 16'h0000, rd;
  logic [3:0] i_loc_irq_req = 4'h0;
  logic [2:0] i_jmp_base = 3'h2;
  logic [5:0] i_jmp_am = 6'h3D;
  logic [31:0] seed = 32'h00008834;
  logic [16:0] edge_ofs [4] = '{17'h08000, 17'h080FE, 17'h08100, 17'h1FFFE};
  logic [15:0] mem [int];
  int miscompares = 0, checks_done = 0, irq_cnt = 0, rst_cnt = 0;
  wire [23:1] i_vme_addr;
  wire [5:0] i_vme_am;
  wire [2:0] i_vme_iack_level;
  wire [15:0] i_vme_data, o_vme_data, o_loc_rdata;
  wire [6:0] o_vme_irq_n;
  wire i_vme_as_n, i_vme_ds0_n, i_vme_ds1_n, i_vme_write_n, i_vme_iack_n;
  wire o_vme_data_oe, o_vme_dtack_n, o_sysfail_n, o_loc_irq, o_loc_reset;
  always #20 i_clock = ~i_clock;
  slave_port #(.WDOG_CYCLES(WDOG)) dut_u (.i_clock, .i_rst, .i_vme_addr, .i_vme_am, .i_vme_as_n,
    .i_vme_ds0_n, .i_vme_ds1_n, .i_vme_write_n, .i_vme_data, .i_vme_iack_n, .i_vme_iack_level,
    .i_jmp_base, .i_jmp_am, .i_loc_cycle, .i_loc_we, .i_loc_be, .i_loc_addr, .i_loc_wdata,
    .i_loc_init_done, .i_loc_error, .i_wdog_kick, .i_loc_irq_req, .o_vme_data, .o_vme_data_oe,
    .o_vme_dtack_n, .o_vme_irq_n, .o_sysfail_n, .o_loc_rdata, .o_loc_irq, .o_loc_reset);
  host_master host_u (.i_clock, .i_dtack_n(o_vme_dtack_n), .i_data(o_vme_data),
    .o_addr(i_vme_addr), .o_am(i_vme_am), .o_as_n(i_vme_as_n), .o_ds0_n(i_vme_ds0_n),
    .o_ds1_n(i_vme_ds1_n), .o_write_n(i_vme_write_n), .o_data(i_vme_data),
    .o_iack_n(i_vme_iack_n), .o_iack_level(i_vme_iack_level));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Random local cycles steal slots from the host port
  always @(posedge i_clock) begin
    #1;
    if (o_loc_irq) irq_cnt++;
    if (o_loc_reset) rst_cnt++;
    if (kick_en) i_wdog_kick = ~i_wdog_kick;
    if (rnd) i_loc_cycle = xs() > 32'h7FFFFFFF;
  end
  task wait_n(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task hx(input logic wr, input logic [16:0] off, input logic [15:0] d, input logic [1:0] be);
    logic [23:0] a;
    a = 24'h040000 | off;
    host_u.xfer(wr, 1'b0, a[23:1], 6'h3D, be, d, rd, ok);
    check({15'h0, ok}, 16'h0001);
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    test_done();
  end
  initial begin
    int i, lvl;
    logic [16:0] off;
    wait_n(5);
    i_rst = 1'b0;
    check({15'h0, o_sysfail_n, o_loc_reset}, 16'h0001);
    wait_n(24);
    check({15'h0, o_sysfail_n, o_loc_reset}, 16'h0000);
    i_loc_init_done = 1'b1;
    wait_n(6);
    check({15'h0, o_sysfail_n}, 16'h0001);
    rnd = 1'b1;
    for (i = 0; i < 12; i++) begin
      off = (i < 4) ? edge_ofs[i] : 17'h08000 + 17'(xs() % 32'h18000);
      off[0] = 1'b0;
      mem[off[16:1]] = 16'(xs());
      hx(1'b1, off, mem[off[16:1]], 2'h3);
    end
    hx(1'b1, 17'h08100, 16'hA5C3, 2'h2);
    mem[32'h4080][15:8] = 8'hA5;
    foreach (mem[k]) begin
      hx(1'b0, {k[15:0], 1'b0}, 16'h0000, 2'h3);
      check(rd, mem[k]);
    end
    rnd = 1'b0;
    i_loc_cycle = 1'b0;
    hx(1'b1, 17'h08000, 16'h3C5A, 2'h3);
    i_loc_cycle = 1'b1;
    i_loc_addr = 15'h4000;
    wait_n(1);
    check(o_loc_rdata, 16'h3C5A);
    i_loc_we = 1'b1;
    i_loc_addr = 15'h4001;
    i_loc_wdata = 16'h9E17;
    wait_n(1);
    {i_loc_cycle, i_loc_we} = 2'h0;
    hx(1'b0, 17'h08002, 16'h0000, 2'h3);
    check(rd, 16'h9E17);
    hx(1'b1, 17'h00800, 16'hFFFF, 2'h3);
    hx(1'b0, 17'h00800, 16'h0000, 2'h3);
    check(rd & 16'h000F, 16'h0000);
    i_loc_error = 1'b1;
    wait_n(6);
    hx(1'b0, 17'h00FFE, 16'h0000, 2'h3);
    check({rd[15:1] & 15'h0004, o_sysfail_n}, 16'h0008);
    i_loc_error = 1'b0;
    host_u.xfer(1'b0, 1'b0, 23'h020400, 6'h39, 2'h3, 16'h0000, rd, ok);
    check({15'h0, ok}, 16'h0000);
    host_u.xfer(1'b0, 1'b0, 23'h030400, 6'h3D, 2'h3, 16'h0000, rd, ok);
    check({15'h0, ok}, 16'h0000);
    {i_jmp_base, i_jmp_am} = {3'h3, 6'h39};
    host_u.xfer(1'b0, 1'b0, 23'h030400, 6'h39, 2'h3, 16'h0000, rd, ok);
    check({15'h0, ok}, 16'h0001);
    {i_jmp_base, i_jmp_am} = {3'h2, 6'h3D};
    for (lvl = 1; lvl < 8; lvl++) begin
      hx(1'b1, 17'(lvl % 4 * 2), 16'(lvl), 2'h1);
      hx(1'b1, 17'(8 + lvl % 4 * 2), 16'(8'h40 + lvl), 2'h1);
      hx(1'b0, 17'(8 + lvl % 4 * 2), 16'h0000, 2'h1);
      check(rd & 16'h00FF, 16'(8'h40 + lvl));
      i_loc_irq_req[lvl % 4] = 1'b1;
      wait_n(4);
      i_loc_irq_req = 4'h0;
      wait_n(4);
      check({9'h0, o_vme_irq_n}, {9'h0, ~(7'h01 << (lvl - 1))});
      host_u.xfer(1'b0, 1'b1, 23'(lvl), 6'h3D, 2'h1, 16'h0000, rd, ok);
      check(rd & 16'h00FF, 16'(8'h40 + lvl));
      wait_n(4);
      check({9'h0, o_vme_irq_n}, 16'h007F);
    end
    i = irq_cnt;
    hx(1'b0, 17'h01000, 16'h0000, 2'h3);
    hx(1'b0, 17'h017FE, 16'h0000, 2'h3);
    hx(1'b1, 17'h01000, 16'h0000, 2'h3);
    wait_n(2);
    check(16'(irq_cnt - i), 16'h0002);
    rst_cnt = 0;
    hx(1'b0, 17'h01800, 16'h0000, 2'h3);
    i_loc_init_done = 1'b0;
    wait_n(20);
    check({16'(rst_cnt) << 1} | o_sysfail_n, 16'h0020);
    i_loc_init_done = 1'b1;
    kick_en = 1'b0;
    wait_n(WDOG + 10);
    hx(1'b0, 17'h00800, 16'h0000, 2'h3);
    check({rd[15:1] & 15'h0001, o_sysfail_n}, 16'h0002);
    test_done();
  end
endmodule
bind slave_port slave_port_assertions #(.WDOG_CYCLES(WDOG_CYCLES)) chk_u (.i_clock, .i_rst,
  .i_vme_addr, .i_vme_am, .i_vme_as_n, .i_vme_write_n, .i_vme_iack_n, .i_jmp_base, .i_jmp_am,
  .i_loc_error, .i_wdog_kick, .o_vme_data_oe, .o_vme_dtack_n, .o_vme_irq_n, .o_sysfail_n,
  .o_loc_irq, .o_loc_reset);

// File: verilog/bus_interrupter.v
// Four-channel backplane interrupter with host-programmed level and vector
`timescale 1ns/1ps
module bus_interrupter #(
  parameter CH = 4
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_wr,
  input wire [1:0] i_ch,
  input wire i_sel_vec,
  input wire [7:0] i_wdata,
  input wire [CH-1:0] i_req,
  input wire i_iack,
  input wire [2:0] i_iack_level,
  output reg [7:0] o_rdata,
  output reg [7:0] o_iack_vector,
  output reg o_iack_hit,
  output reg [6:0] o_irq_n
);
  reg [2:0] level_reg [0:CH-1];
  reg [7:0] vector_reg [0:CH-1];
  reg [CH-1:0] pend_reg;
  reg [6:0] irq_next;
  reg [7:0] vec_next;
  reg hit_next;
  integer k;
  always @* begin
    irq_next = 7'h7F;
    vec_next = 8'h0F;
    hit_next = 1'b0;
    for (k = CH - 1; k >= 0; k = k - 1) begin
      if (pend_reg[k] && level_reg[k] != 3'h0) begin
        irq_next[level_reg[k] - 3'h1] = 1'b0;
        if (level_reg[k] == i_iack_level) begin
          vec_next = vector_reg[k];
          hit_next = 1'b1;
        end
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < CH; g = g + 1) begin : chan
      always @(posedge i_clock) begin
        if (i_rst) begin
          level_reg[g] <= 3'h0;
          vector_reg[g] <= 8'h0F;
          pend_reg[g] <= 1'b0;
        end else begin
          if (i_wr && i_ch == g && !i_sel_vec) begin
            level_reg[g] <= i_wdata[2:0];
          end
          if (i_wr && i_ch == g && i_sel_vec) begin
            vector_reg[g] <= i_wdata;
          end
          if (i_req[g]) begin
            pend_reg[g] <= 1'b1;
          end else if (i_iack && hit_next && level_reg[g] == i_iack_level) begin
            pend_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_iack_vector <= 8'h0F;
      o_iack_hit <= 1'b0;
      o_irq_n <= 7'h7F;
    end else begin
      o_rdata <= i_sel_vec ? vector_reg[i_ch] : {5'h00, level_reg[i_ch]};
      o_iack_vector <= vec_next;
      o_iack_hit <= i_iack && hit_next;
      o_irq_n <= irq_next;
    end
  end
endmodule

// File: verilog/slave_port.v
// Backplane slave port: window decode, shared memory, triggers, fail line, watchdog
`timescale 1ns/1ps
`include "slave_port_regs.vh"
// Contract
// - Host read in local-interrupt range pulses interrupt to local processor.
// - Host read in local-reset range resets local processor and peripherals.
// - Status location is read only; host writes leave it unchanged.
// - Lowest window range decodes to the bus interrupter registers.
// - Sixteen command blocks in command range, shared by host and local side.
// - Sixteen data arrays fill the rest of the window.
// - Fail line active during power-up and after a local reset.
// - Local error output asserts the fail line.
// - Missed watchdog retrigger from timer chip asserts the fail line.
// - Host cycles are served between local cycles; local never waits.
// - Host read data is latched and handshake completes decoupled from memory.
// - Decode jumper base on 128 Kbyte boundary, A24, jumper modifier, D8/D16.
// - Four interrupter channels, each level one to seven with a vector.
// - Local side raises requests; host may reprogram levels and vectors anytime.
// - Backplane system reset resets local processor and local devices.
module slave_port #(
  parameter WDOG_CYCLES = `WDOG_CYC,
  parameter MEM_WORDS = 65536
) (
  input wire i_clock,
  input wire i_rst,
  input wire [23:1] i_vme_addr,
  input wire [5:0] i_vme_am,
  input wire i_vme_as_n,
  input wire i_vme_ds0_n,
  input wire i_vme_ds1_n,
  input wire i_vme_write_n,
  input wire [15:0] i_vme_data,
  input wire i_vme_iack_n,
  input wire [2:0] i_vme_iack_level,
  input wire [2:0] i_jmp_base,
  input wire [5:0] i_jmp_am,
  input wire i_loc_cycle,
  input wire i_loc_we,
  input wire [1:0] i_loc_be,
  input wire [15:1] i_loc_addr,
  input wire [15:0] i_loc_wdata,
  input wire i_loc_init_done,
  input wire i_loc_error,
  input wire i_wdog_kick,
  input wire [3:0] i_loc_irq_req,
  output reg [15:0] o_vme_data,
  output reg o_vme_data_oe,
  output reg o_vme_dtack_n,
  output reg [6:0] o_vme_irq_n,
  output reg o_sysfail_n,
  output reg [15:0] o_loc_rdata,
  output reg o_loc_irq,
  output reg o_loc_reset
);
  reg [1:0] as_s_reg;
  reg [1:0] ds_s_reg0;
  reg [1:0] ds_s_reg1;
  reg [1:0] iack_s_reg;
  reg [2:0] kick_s_reg;
  reg [1:0] err_s_reg;
  reg [1:0] init_s_reg;
  reg [3:0] req_s_reg0;
  reg [3:0] req_s_reg1;
  reg [15:0] mem [0:MEM_WORDS-1];
  reg [1:0] state_reg;
  reg [15:0] latch_reg;
  reg [7:0] lrst_cnt_reg;
  reg init_reg;
  reg wdog_fail_reg;
  reg [31:0] wdog_cnt_reg;
  reg int_wr_reg;
  reg [7:0] int_wdata_reg;
  wire [7:0] int_rdata;
  wire [7:0] iack_vec;
  wire iack_hit;
  wire [6:0] irq_n;
  localparam ST_IDLE = 2'h0;
  localparam ST_SERVE = 2'h1;
  localparam ST_ACK = 2'h2;
  localparam ST_WAIT = 2'h3;
  function in_range;
    input [16:0] a;
    input [16:0] lo;
    input [16:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction
  wire as_act = as_s_reg[1];
  wire ds_act = !ds_s_reg0[1] || !ds_s_reg1[1];
  wire [16:0] ofs = {i_vme_addr[16:1], 1'b0};
  wire am_ok = (i_vme_am == i_jmp_am);
  wire sel = as_act && iack_s_reg[1] && am_ok && (i_vme_addr[23:17] == {4'h0, i_jmp_base});
  wire hwrite = !i_vme_write_n;
  wire [15:0] word_idx = i_vme_addr[16:1];
  wire hit_intr = in_range(ofs, `OFS_INTR_LO, `OFS_INTR_HI);
  wire hit_stat = in_range(ofs, `OFS_STAT_LO, `OFS_STAT_HI);
  wire hit_lirq = in_range(ofs, `OFS_LIRQ_LO, `OFS_LIRQ_HI);
  wire hit_lrst = in_range(ofs, `OFS_LRST_LO, `OFS_LRST_HI);
  wire hit_mem = !(hit_intr || hit_stat || hit_lirq || hit_lrst);
  wire [15:0] status_word = {12'h000, err_s_reg[1], init_reg, wdog_fail_reg, !o_sysfail_n};
  wire wdog_ok = (wdog_cnt_reg < WDOG_CYCLES);
  // Local side owns the memory in this cycle; host only takes idle slots
  wire host_slot = !i_loc_cycle;
  always @(posedge i_clock) begin
    as_s_reg <= {as_s_reg[0], !i_vme_as_n};
    ds_s_reg0 <= {ds_s_reg0[0], i_vme_ds0_n};
    ds_s_reg1 <= {ds_s_reg1[0], i_vme_ds1_n};
    iack_s_reg <= {iack_s_reg[0], i_vme_iack_n};
    kick_s_reg <= {kick_s_reg[1:0], i_wdog_kick};
    err_s_reg <= {err_s_reg[0], i_loc_error};
    init_s_reg <= {init_s_reg[0], i_loc_init_done};
    req_s_reg0 <= i_loc_irq_req;
    req_s_reg1 <= req_s_reg0;
  end
  // Local port: zero wait states, reads return next edge
  // Host writes only use slots the local side leaves free, so the ports never clash
  always @(posedge i_clock) begin
    if (i_loc_cycle && i_loc_we && i_loc_be[0]) begin
      mem[i_loc_addr][7:0] <= i_loc_wdata[7:0];
    end
    if (i_loc_cycle && i_loc_we && i_loc_be[1]) begin
      mem[i_loc_addr][15:8] <= i_loc_wdata[15:8];
    end
    if (state_reg == ST_SERVE && host_slot && sel && hwrite && hit_mem) begin
      if (!ds_s_reg0[1]) begin
        mem[word_idx][7:0] <= i_vme_data[7:0];
      end
      if (!ds_s_reg1[1]) begin
        mem[word_idx][15:8] <= i_vme_data[15:8];
      end
    end
  end
  always @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      latch_reg <= 16'h0000;
      o_vme_data <= 16'h0000;
      o_vme_data_oe <= 1'b0;
      o_vme_dtack_n <= 1'b1;
      o_loc_irq <= 1'b0;
      int_wr_reg <= 1'b0;
      int_wdata_reg <= 8'h00;
      o_loc_rdata <= 16'h0000;
    end else begin
      o_loc_irq <= 1'b0;
      int_wr_reg <= 1'b0;
      o_loc_rdata <= mem[i_loc_addr];
      case (state_reg)
        ST_IDLE: begin
          if (sel && ds_act) begin
            state_reg <= ST_SERVE;
          end else if (as_act && !iack_s_reg[1] && iack_hit) begin
            o_vme_data <= {8'h00, iack_vec};
            o_vme_data_oe <= 1'b1;
            state_reg <= ST_ACK;
          end
        end
        ST_SERVE: begin
          if (!sel) begin
            state_reg <= ST_IDLE;
          end else if (host_slot) begin
            int_wdata_reg <= i_vme_data[7:0];
            int_wr_reg <= hwrite && hit_intr;
            // Status writes fall through: no storage is touched
            if (!hwrite) begin
              if (hit_stat) begin
                latch_reg <= status_word;
              end else if (hit_intr) begin
                latch_reg <= {8'h00, int_rdata};
              end else if (hit_mem) begin
                latch_reg <= mem[word_idx];
              end else begin
                latch_reg <= 16'h0000;
              end
              o_loc_irq <= hit_lirq;
            end
            state_reg <= ST_ACK;
          end
        end
        ST_ACK: begin
          // Handshake runs from the latch, memory is already free
          o_vme_data <= (state_reg == ST_ACK && o_vme_data_oe) ? o_vme_data : latch_reg;
          o_vme_data_oe <= !hwrite || !iack_s_reg[1];
          o_vme_dtack_n <= 1'b0;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!as_act && !ds_act) begin
            o_vme_dtack_n <= 1'b1;
            o_vme_data_oe <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // Local reset pulse, system reset, fail line and watchdog
  always @(posedge i_clock) begin
    if (i_rst) begin
      lrst_cnt_reg <= `LRST_PULSE_CYC;
      o_loc_reset <= 1'b1;
      init_reg <= 1'b1;
      wdog_cnt_reg <= 32'h00000000;
      wdog_fail_reg <= 1'b0;
      o_sysfail_n <= 1'b0;
    end else begin
      if (state_reg == ST_SERVE && host_slot && sel && !hwrite && hit_lrst) begin
        lrst_cnt_reg <= `LRST_PULSE_CYC;
      end else if (lrst_cnt_reg != 8'h00) begin
        lrst_cnt_reg <= lrst_cnt_reg - 8'h01;
      end
      o_loc_reset <= (lrst_cnt_reg != 8'h00);
      if (lrst_cnt_reg != 8'h00) begin
        init_reg <= 1'b1;
      end else if (init_s_reg[1]) begin
        init_reg <= 1'b0;
      end
      if (lrst_cnt_reg != 8'h00 || (kick_s_reg[2] != kick_s_reg[1])) begin
        wdog_cnt_reg <= 32'h00000000;
        wdog_fail_reg <= 1'b0;
      end else if (wdog_ok) begin
        wdog_cnt_reg <= wdog_cnt_reg + 32'h00000001;
      end else begin
        wdog_fail_reg <= 1'b1;
      end
      o_sysfail_n <= !(init_reg || err_s_reg[1] || wdog_fail_reg);
    end
  end
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_vme_irq_n <= 7'h7F;
    end else begin
      o_vme_irq_n <= irq_n;
    end
  end
  // Channel select comes from the held address so read-back is already current
  bus_interrupter #(
    .CH(`INTR_CHANNELS)
  ) u_intr (
    .i_clock(i_clock),
    .i_rst(i_rst || o_loc_reset),
    .i_wr(int_wr_reg),
    .i_ch(ofs[2:1]),
    .i_sel_vec(ofs[3]),
    .i_wdata(int_wdata_reg),
    .i_req(req_s_reg1),
    .i_iack(state_reg == ST_IDLE && as_act && !iack_s_reg[1]),
    .i_iack_level(i_vme_iack_level),
    .o_rdata(int_rdata),
    .o_iack_vector(iack_vec),
    .o_iack_hit(iack_hit),
    .o_irq_n(irq_n)
  );
endmodule

// File: verilog/slave_port_regs.vh
// Window offsets, field positions and timing counts of the backplane slave port
`ifndef SLAVE_PORT_REGS_VH
`define SLAVE_PORT_REGS_VH
`define WIN_AW 17
`define OFS_INTR_LO 17'h00000
`define OFS_INTR_HI 17'h007FF
`define OFS_STAT_LO 17'h00800
`define OFS_STAT_HI 17'h00FFF
`define OFS_LIRQ_LO 17'h01000
`define OFS_LIRQ_HI 17'h017FF
`define OFS_LRST_LO 17'h01800
`define OFS_LRST_HI 17'h01FFF
`define OFS_FW_LO 17'h02000
`define OFS_FW_HI 17'h07FFF
`define OFS_CMD_LO 17'h08000
`define OFS_CMD_HI 17'h080FF
`define OFS_DATA_LO 17'h08100
`define OFS_DATA_HI 17'h1FFFF
`define CMD_BLOCKS 16
`define INTR_CHANNELS 4
`define STAT_SYSFAIL_BIT 0
`define STAT_WDOG_BIT 1
`define STAT_INIT_BIT 2
`define STAT_ERR_BIT 3
`define LRST_PULSE_CYC 8'h10
`define WDOG_TIME_US 1000
`define CLK_MHZ 25
`define WDOG_CYC (`WDOG_TIME_US * `CLK_MHZ)
`endif
